// file: hdl/flash_lock_pkg.sv
// shared constants, types and lock decoding for the lock gate
package flash_lock_pkg;
  // lock byte values and count
  localparam logic [7:0] LOCK_UNPROG = 8'hff;
  localparam logic [7:0] LOCK_PROG = 8'h00;
  localparam int LOCK_COUNT = 3;
  localparam logic [15:0] LOCK_LAST = 16'h0002;
  // start of the protected external region, 32K
  localparam logic [15:0] EXT_LIMIT = 16'h8000;
  // service commands and block starts
  localparam logic [7:0] CMD_READ_ID = 8'h00;
  localparam logic [7:0] CMD_ERASE_BLOCK = 8'h01;
  localparam logic [7:0] CMD_PROG_BYTE = 8'h02;
  localparam logic [7:0] BLK0_START = 8'h00;
  localparam logic [7:0] BLK1_START = 8'h20;
  localparam logic [7:0] BLK2_START = 8'h40;
  localparam logic [7:0] BLK3_START = 8'h80;
  localparam logic [15:0] ERASE_DP1 = 16'h0000;
  localparam logic [15:0] ID_COUNT = 16'h0004;
  localparam logic [7:0] ACC_DONE = 8'h00;
  // register byte offsets
  localparam int REG_ADDR_W = 8;
  localparam logic [7:0] REG_AUX = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_ACC = 8'h08;
  localparam logic [7:0] REG_DP0 = 8'h0c;
  localparam logic [7:0] REG_DP1 = 8'h10;
  localparam logic [7:0] REG_GO = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_LOCKS = 8'h1c;
  localparam logic [7:0] REG_EXT = 8'h20;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {MOP_READ, MOP_PROG, MOP_BLK_ERASE,
    MOP_CHIP_ERASE} mem_op_t;
  typedef enum logic [2:0] {SPACE_CODE, SPACE_DATA, SPACE_USIG,
    SPACE_MSIG, SPACE_FUSE, SPACE_LOCK} space_t;
  typedef enum logic [1:0] {PROT_NONE, PROT_NO_PROG, PROT_NO_READ,
    PROT_NO_EXT} prot_t;

  // any cleared bit counts as programmed, so odd patterns lean strict
  function automatic prot_t decode_prot(input logic [23:0] locks);
    if (locks[23:16] != LOCK_UNPROG) decode_prot = PROT_NO_EXT;
    else if (locks[15:8] != LOCK_UNPROG) decode_prot = PROT_NO_READ;
    else if (locks[7:0] != LOCK_UNPROG) decode_prot = PROT_NO_PROG;
    else decode_prot = PROT_NONE;
  endfunction
endpackage

// file: hdl/lock_store.sv
// lock byte store: program to 00h, erase all to ffh, registered read
module lock_store
  import flash_lock_pkg::*;
#(
  parameter int DEPTH = LOCK_COUNT
)(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // update
  input wire logic i_program,
  input wire logic [1:0] i_prog_index,
  input wire logic i_erase_all,
  // read
  input wire logic [1:0] i_rd_index,
  output logic [7:0] o_rdata,
  output logic [8*DEPTH-1:0] o_bytes
);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [7:0] rdata;
  } store_t;

  store_t st;
  store_t next_st;

  always_comb begin
    next_st = st;
    next_st.rdata = (int'(i_rd_index) < DEPTH) ?
      st.mem[i_rd_index] : LOCK_UNPROG;
    // erase beats a same-cycle program; nothing else raises a bit
    if (i_erase_all) begin
      next_st.mem = {DEPTH{LOCK_UNPROG}};
    end else if (i_program && int'(i_prog_index) < DEPTH) begin
      next_st.mem[i_prog_index] = LOCK_PROG;
    end
  end

  // flops stand in for the nonvolatile cells
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '{mem: {DEPTH{LOCK_UNPROG}}, rdata: LOCK_UNPROG};
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_bytes = st.mem;
endmodule // lock_store

// file: hdl/iap_sequencer.sv
// in-application service: id read, block erase, byte program
module iap_sequencer
  import flash_lock_pkg::*;
#(
  // arbitrary identity bytes, index 0 in the low byte
  parameter logic [31:0] ID_BYTES = 32'h5a_a5_3c_c3
)(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // call
  input wire logic i_start,
  input wire logic i_rom_mapped,
  input wire logic [7:0] i_cmd,
  input wire logic [7:0] i_acc,
  input wire logic [15:0] i_first_data_pointer,
  input wire logic [15:0] i_second_data_pointer,
  output logic o_busy,
  output logic o_done,
  output logic o_err,
  output logic [7:0] o_acc,
  // memory request, held until done
  output logic o_mem_req,
  output mem_op_t o_mem_op,
  output logic [15:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  input wire logic i_mem_done
);
  typedef enum logic {SQ_IDLE, SQ_MEM} seq_state_t;
  typedef struct packed {
    seq_state_t state;
    logic [7:0] cmd;
    logic done;
    logic err;
    logic [7:0] acc;
    logic req;
    mem_op_t op;
    logic [15:0] addr;
    logic [7:0] wdata;
  } seq_t;

  seq_t s;
  seq_t next_s;
  logic blk_ok;

  assign blk_ok = (i_first_data_pointer[15:8] == BLK0_START ||
    i_first_data_pointer[15:8] == BLK1_START || i_first_data_pointer[15:8] == BLK2_START ||
    i_first_data_pointer[15:8] == BLK3_START) && i_second_data_pointer == ERASE_DP1;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    unique case (s.state)
      SQ_IDLE: if (i_start) begin
        next_s.cmd = i_cmd;
        next_s.err = 1'b0;
        next_s.done = 1'b1;
        // unmapped rom means the call never reached the service
        if (!i_rom_mapped) begin
          next_s.err = 1'b1;
        end else if (i_cmd == CMD_READ_ID) begin
          if (i_first_data_pointer < ID_COUNT) begin
            next_s.acc = ID_BYTES[8*i_first_data_pointer[1:0] +: 8];
          end else begin
            next_s.err = 1'b1;
          end
        end else if (i_cmd == CMD_ERASE_BLOCK && blk_ok) begin
          next_s.done = 1'b0;
          next_s.state = SQ_MEM;
          next_s.req = 1'b1;
          next_s.op = MOP_BLK_ERASE;
          next_s.addr = {i_first_data_pointer[15:8], ACC_DONE};
        end else if (i_cmd == CMD_PROG_BYTE) begin
          next_s.done = 1'b0;
          next_s.state = SQ_MEM;
          next_s.req = 1'b1;
          next_s.op = MOP_PROG;
          next_s.addr = i_first_data_pointer;
          next_s.wdata = i_acc;
        end else begin
          next_s.err = 1'b1;
        end
      end
      SQ_MEM: if (i_mem_done) begin
        next_s.req = 1'b0;
        next_s.state = SQ_IDLE;
        next_s.done = 1'b1;
        next_s.acc = (s.cmd == CMD_PROG_BYTE) ?
          ACC_DONE : s.addr[15:8];
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_busy = (s.state != SQ_IDLE);
  assign o_done = s.done;
  assign o_err = s.err;
  assign o_acc = s.acc;
  assign o_mem_req = s.req;
  assign o_mem_op = s.op;
  assign o_mem_addr = s.addr;
  assign o_mem_wdata = s.wdata;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  AST_ERASE_RETURNS_DPH: assert property (
    s.state == SQ_MEM && i_mem_done && s.cmd == CMD_ERASE_BLOCK
    |=> o_done && !o_err && o_acc == $past(s.addr[15:8]))
    else $error("erase did not return the block start");
  AST_ID_READ_ANSWERS: assert property (
    s.state == SQ_IDLE && i_start && i_rom_mapped &&
    i_cmd == CMD_READ_ID && i_first_data_pointer < ID_COUNT
    |=> o_done && !o_err && !o_mem_req)
    else $error("id read not answered next cycle");
  AST_PROG_REQUEST: assert property (
    s.state == SQ_IDLE && i_start && i_rom_mapped &&
    i_cmd == CMD_PROG_BYTE
    |=> o_mem_req && o_mem_op == MOP_PROG &&
    o_mem_addr == $past(i_first_data_pointer) && o_mem_wdata == $past(i_acc))
    else $error("byte program request wrong");
  AST_PROG_RETURNS_ZERO: assert property (
    s.state == SQ_MEM && i_mem_done && s.cmd == CMD_PROG_BYTE
    |=> o_done && o_acc == ACC_DONE)
    else $error("byte program did not return zero");
  COVER_PROG_DONE: cover property (
    s.state == SQ_MEM && i_mem_done && s.cmd == CMD_PROG_BYTE);
endmodule // iap_sequencer

// file: hdl/flash_lock_and_iap_gate.sv
// lock level gate for the serial port and the in-app service
// Notes on behaviour
// - three lock bytes, ffh clear, 00h set
// - only chip erase returns lock bytes to ffh
// - lock bytes 00h,01h,02h pick modes 1-4
// - mode 2 refuses all serial port programming except of lock bytes
// - mode 3 also refuses serial code/data reads
// - signatures and fuses stay readable when locked
// - mode 4 blocks external fetch above 32K while ext_sel is set
// - levels never gate loader or app programming
// - command, accumulator, pointers pick id read, erase
// - command 02h programs accumulator byte, returns zero
module flash_lock_and_iap_gate
  import flash_lock_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // axi4-lite write
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [REG_ADDR_W-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // axi4-lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [REG_ADDR_W-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // serial programming port
  input wire logic i_sp_valid,
  input wire mem_op_t i_sp_op,
  input wire space_t i_sp_space,
  input wire logic [15:0] i_sp_addr,
  input wire logic [7:0] i_sp_wdata,
  output logic o_sp_ready,
  output logic o_sp_done,
  output logic o_sp_denied,
  output logic [7:0] o_sp_rdata,
  // flash array controller
  output logic o_mem_req,
  output mem_op_t o_mem_op,
  output space_t o_mem_space,
  output logic [15:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  output logic o_mem_from_app,
  input wire logic i_mem_done,
  input wire logic [7:0] i_mem_rdata,
  // external fetch check and rom map
  input wire logic i_fetch_valid,
  input wire logic [15:0] i_fetch_addr,
  output logic o_fetch_deny,
  output logic o_rom_map_enable
);
  typedef enum logic [1:0] {T_IDLE, T_LOCK_RD, T_SP_MEM,
    T_IAP_MEM} gate_state_t;
  typedef struct packed {
    gate_state_t state;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [REG_ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rom_map;
    logic ext_sel;
    logic go;
    logic [7:0] cmd;
    logic [7:0] acc;
    logic [15:0] dp0;
    logic [15:0] dp1;
    logic sp_ready;
    logic sp_done;
    logic sp_denied;
    logic [7:0] sp_rdata;
    logic mem_req;
    mem_op_t mem_op;
    space_t mem_space;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
    logic mem_from_app;
    logic fetch_deny;
  } gate_t;

  gate_t r;
  gate_t next_r;
  logic [23:0] locks;
  logic [7:0] lock_rdata;
  prot_t prot;
  logic lock_prog;
  logic lock_erase;
  logic [1:0] lock_idx;
  logic sp_take;
  logic wr_fire;
  logic [31:0] wm;
  logic seq_busy;
  logic seq_done;
  logic seq_err;
  logic [7:0] seq_acc;
  logic seq_req;
  mem_op_t seq_op;
  logic [15:0] seq_addr;
  logic [7:0] seq_wdata;
  logic seq_mem_done;

  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] val, input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) merge[8*i +: 8] = val[8*i +: 8];
    end
  endfunction

  function automatic logic mapped(input logic [REG_ADDR_W-1:0] a);
    mapped = a == REG_AUX || a == REG_CMD || a == REG_ACC ||
      a == REG_DP0 || a == REG_DP1 || a == REG_GO ||
      a == REG_STATUS || a == REG_LOCKS || a == REG_EXT;
  endfunction

  function automatic logic [31:0] read_word(
    input logic [REG_ADDR_W-1:0] a, input gate_t g, input prot_t p,
    input logic busy, input logic err, input logic [23:0] lk);
    read_word = 32'h0;
    case (a)
      REG_AUX: read_word = {31'h0, g.rom_map};
      REG_CMD: read_word = {24'h0, g.cmd};
      REG_ACC: read_word = {24'h0, g.acc};
      REG_DP0: read_word = {16'h0, g.dp0};
      REG_DP1: read_word = {16'h0, g.dp1};
      REG_STATUS: read_word = {25'h0, p == PROT_NO_EXT && g.ext_sel,
        p >= PROT_NO_READ, p != PROT_NONE, err, busy, p};
      REG_LOCKS: read_word = {8'h0, lk};
      REG_EXT: read_word = {31'h0, g.ext_sel};
      default: read_word = 32'h0;
    endcase
  endfunction

  // lock space is handled apart, so no entry here; chip erase always passes
  function automatic logic sp_allowed(input prot_t m,
    input mem_op_t op, input space_t sp);
    if (op == MOP_CHIP_ERASE) sp_allowed = 1'b1;
    else if (op != MOP_READ) sp_allowed = (m == PROT_NONE);
    else if (sp == SPACE_CODE || sp == SPACE_DATA)
      sp_allowed = (m < PROT_NO_READ);
    else sp_allowed = 1'b1;
  endfunction

  assign prot = decode_prot(locks);
  assign sp_take = i_sp_valid && r.sp_ready;
  assign wr_fire = r.aw_got && r.w_got && !r.bvalid;
  assign wm = merge(read_word(r.awaddr, r, prot, seq_busy, seq_err,
    locks), r.wdata, r.wstrb);
  assign seq_mem_done = (r.state == T_IAP_MEM) && i_mem_done;

  lock_store u_locks (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_program(lock_prog),
    .i_prog_index(lock_idx),
    .i_erase_all(lock_erase),
    // index follows the request in idle, else a lock read answers stale
    .i_rd_index(r.state == T_IDLE ? lock_idx : r.mem_addr[1:0]),
    .o_rdata(lock_rdata),
    .o_bytes(locks)
  );

  iap_sequencer u_seq (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_start(r.go),
    .i_rom_mapped(r.rom_map),
    .i_cmd(r.cmd),
    .i_acc(r.acc),
    .i_first_data_pointer(r.dp0),
    .i_second_data_pointer(r.dp1),
    .o_busy(seq_busy),
    .o_done(seq_done),
    .o_err(seq_err),
    .o_acc(seq_acc),
    .o_mem_req(seq_req),
    .o_mem_op(seq_op),
    .o_mem_addr(seq_addr),
    .o_mem_wdata(seq_wdata),
    .i_mem_done(seq_mem_done)
  );

  always_comb begin
    next_r = r;
    next_r.sp_done = 1'b0;
    next_r.sp_denied = 1'b0;
    next_r.go = 1'b0;
    lock_prog = 1'b0;
    lock_erase = 1'b0;
    lock_idx = i_sp_addr[1:0];
    // register bus: address and data taken in either order
    if (i_awvalid && r.awready) begin
      next_r.aw_got = 1'b1;
      next_r.awaddr = i_awaddr;
    end
    if (i_wvalid && r.wready) begin
      next_r.w_got = 1'b1;
      next_r.wdata = i_wdata;
      next_r.wstrb = i_wstrb;
    end
    if (r.bvalid && i_bready) next_r.bvalid = 1'b0;
    if (wr_fire) begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = mapped(r.awaddr) ? RESP_OKAY : RESP_SLVERR;
      case (r.awaddr)
        REG_AUX: next_r.rom_map = wm[0];
        REG_CMD: next_r.cmd = wm[7:0];
        REG_ACC: next_r.acc = wm[7:0];
        REG_DP0: next_r.dp0 = wm[15:0];
        REG_DP1: next_r.dp1 = wm[15:0];
        REG_GO: next_r.go = wm[0] && !seq_busy;
        REG_EXT: next_r.ext_sel = wm[0];
        default: next_r.go = 1'b0;
      endcase
    end
    // the service result overrides a same-cycle software write
    if (seq_done) next_r.acc = seq_acc;
    if (r.rvalid && i_rready) next_r.rvalid = 1'b0;
    if (i_arvalid && r.arready) begin
      next_r.rvalid = 1'b1;
      next_r.rdata = read_word(i_araddr, r, prot, seq_busy, seq_err,
        locks);
      next_r.rresp = mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    next_r.awready = !next_r.aw_got;
    next_r.wready = !next_r.w_got;
    next_r.arready = !next_r.rvalid;
    // serial port and memory arbitration, serial first
    unique case (r.state)
      T_IDLE: begin
        next_r.sp_ready = 1'b1;
        if (sp_take) begin
          next_r.sp_done = 1'b1;
          next_r.mem_addr = i_sp_addr;
          if (i_sp_space == SPACE_LOCK && i_sp_op != MOP_CHIP_ERASE) begin
            // lock programming stays open: it can only tighten
            if (i_sp_addr > LOCK_LAST || i_sp_op == MOP_BLK_ERASE) begin
              next_r.sp_denied = 1'b1;
            end else if (i_sp_op == MOP_READ) begin
              next_r.sp_done = 1'b0;
              next_r.sp_ready = 1'b0;
              next_r.state = T_LOCK_RD;
            end else begin
              lock_prog = 1'b1;
            end
          end else if (!sp_allowed(prot, i_sp_op, i_sp_space)) begin
            next_r.sp_denied = 1'b1;
          end else begin
            next_r.sp_done = 1'b0;
            next_r.sp_ready = 1'b0;
            next_r.state = T_SP_MEM;
            next_r.mem_req = 1'b1;
            next_r.mem_op = i_sp_op;
            next_r.mem_space = i_sp_space;
            next_r.mem_wdata = i_sp_wdata;
            next_r.mem_from_app = 1'b0;
          end
        end else if (seq_req) begin
          // no lock check on the application path
          next_r.sp_ready = 1'b0;
          next_r.state = T_IAP_MEM;
          next_r.mem_req = 1'b1;
          next_r.mem_op = seq_op;
          next_r.mem_space = SPACE_CODE;
          next_r.mem_addr = seq_addr;
          next_r.mem_wdata = seq_wdata;
          next_r.mem_from_app = 1'b1;
        end
      end
      T_LOCK_RD: begin
        next_r.sp_done = 1'b1;
        next_r.sp_rdata = lock_rdata;
        next_r.sp_ready = 1'b1;
        next_r.state = T_IDLE;
      end
      T_SP_MEM: if (i_mem_done) begin
        next_r.mem_req = 1'b0;
        next_r.sp_done = 1'b1;
        next_r.sp_rdata = i_mem_rdata;
        next_r.sp_ready = 1'b1;
        next_r.state = T_IDLE;
        lock_erase = (r.mem_op == MOP_CHIP_ERASE);
      end
      T_IAP_MEM: if (i_mem_done) begin
        next_r.mem_req = 1'b0;
        next_r.state = T_IDLE;
      end
    endcase
    next_r.fetch_deny = i_fetch_valid && prot == PROT_NO_EXT &&
      r.ext_sel && i_fetch_addr >= EXT_LIMIT;
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign o_awready = r.awready;
  assign o_wready = r.wready;
  assign o_bvalid = r.bvalid;
  assign o_bresp = r.bresp;
  assign o_arready = r.arready;
  assign o_rvalid = r.rvalid;
  assign o_rdata = r.rdata;
  assign o_rresp = r.rresp;
  assign o_sp_ready = r.sp_ready;
  assign o_sp_done = r.sp_done;
  assign o_sp_denied = r.sp_denied;
  assign o_sp_rdata = r.sp_rdata;
  assign o_mem_req = r.mem_req;
  assign o_mem_op = r.mem_op;
  assign o_mem_space = r.mem_space;
  assign o_mem_addr = r.mem_addr;
  assign o_mem_wdata = r.mem_wdata;
  assign o_mem_from_app = r.mem_from_app;
  assign o_fetch_deny = r.fetch_deny;
  assign o_rom_map_enable = r.rom_map;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  AST_LOCK_VALUES: assert property (
    (locks[7:0] == LOCK_UNPROG || locks[7:0] == LOCK_PROG) &&
    (locks[15:8] == LOCK_UNPROG || locks[15:8] == LOCK_PROG) &&
    (locks[23:16] == LOCK_UNPROG || locks[23:16] == LOCK_PROG))
    else $error("lock byte neither ffh nor 00h");
  AST_LOCK_NO_UNPROGRAM: assert property (
    !lock_erase |=> (locks & ~$past(locks)) == 24'h0)
    else $error("lock bit returned to ffh without chip erase");
  AST_MODE2_DECODE: assert property (
    locks == {LOCK_UNPROG, LOCK_UNPROG, LOCK_PROG}
    |-> prot == PROT_NO_PROG)
    else $error("pattern 00h,ffh,ffh not mode 2");
  AST_ODD_PATTERN: assert property (
    locks[23:16] == LOCK_PROG |-> prot == PROT_NO_EXT)
    else $error("programmed third lock byte not strictest");
  AST_SP_PROG_DENIED: assert property (
    sp_take && i_sp_op == MOP_PROG && i_sp_space != SPACE_LOCK &&
    prot != PROT_NONE |=> o_sp_done && o_sp_denied && !o_mem_req)
    else $error("serial programming passed a lock");
  AST_SP_READ_DENIED: assert property (
    sp_take && i_sp_op == MOP_READ && prot >= PROT_NO_READ &&
    (i_sp_space == SPACE_CODE || i_sp_space == SPACE_DATA)
    |=> o_sp_denied ##1 !o_sp_done)
    else $error("locked code or data read passed");
  AST_SIG_READ_OK: assert property (
    sp_take && i_sp_op == MOP_READ && (i_sp_space == SPACE_USIG ||
    i_sp_space == SPACE_MSIG || i_sp_space == SPACE_FUSE)
    |=> o_mem_req && o_mem_op == MOP_READ && !o_sp_denied)
    else $error("signature or fuse read refused");
  AST_EXT_FETCH: assert property (
    i_fetch_valid && i_fetch_addr >= EXT_LIMIT
    |=> o_fetch_deny == ($past(prot) == PROT_NO_EXT && $past(r.ext_sel)))
    else $error("external fetch gate wrong");
  AST_APP_UNGATED: assert property (
    r.state == T_IDLE && !sp_take && seq_req
    |=> o_mem_req && o_mem_from_app)
    else $error("application request held back");
  COVER_SP_DENIED: cover property (o_sp_done && o_sp_denied);
  COVER_CHIP_ERASE: cover property (lock_erase && locks != 24'hffffff);
  COVER_FETCH_DENY: cover property (o_fetch_deny);
endmodule // flash_lock_and_iap_gate

// file: tb/flash_ctrl_model.sv
// flash array controller model answering the gate's memory requests
module flash_ctrl_model (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // request and answer
  input wire logic i_req,
  input wire logic [15:0] i_addr,
  output logic o_done,
  output logic [7:0] o_rdata
);
  logic [2:0] wait_cnt;
  logic slow;
  // alternate prompt and slow answers so both paths get exercised
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_done <= 1'h0;
      o_rdata <= 8'h00;
      wait_cnt <= 3'h0;
      slow <= 1'h0;
    end else begin
      o_done <= 1'h0;
      // data lines invert every cycle between answers, never hold old value
      o_rdata <= ~o_rdata;
      if (i_req && !o_done) begin
        if (wait_cnt == {slow, 2'h0}) begin
          o_done <= 1'h1;
          o_rdata <= i_addr[7:0] ^ 8'ha5;
          wait_cnt <= 3'h0;
          slow <= ~slow;
        end else begin
          wait_cnt <= wait_cnt + 3'h1;
        end
      end
    end
  end
endmodule // flash_ctrl_model

// file: tb/flash_lock_and_iap_gate_bench.sv
// bench for the lock gate: register bus, serial port and fetch checks
module flash_lock_and_iap_gate_bench import flash_lock_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock, i_resetn = '0, i_awvalid = '0, i_wvalid = '0;
  logic i_bready = '0, i_arvalid = '0, i_rready = '0;
  logic i_sp_valid = '0, i_fetch_valid = '0;
  logic [7:0] i_awaddr = '0, i_araddr = '0, o_sp_rdata, i_mem_rdata;
  logic [31:0] i_wdata = '0, o_rdata;
  logic [15:0] i_sp_addr = '0, i_fetch_addr = '0, o_mem_addr;
  mem_op_t i_sp_op = MOP_READ;
  space_t i_sp_space = SPACE_CODE;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_sp_ready;
  logic o_sp_done, o_sp_denied, o_mem_req, i_mem_done, o_fetch_deny;
  logic [1:0] o_rresp, o_bresp, resp;
  mem_op_t o_mem_op;
  space_t o_mem_space;
  logic o_mem_from_app, o_rom_map_enable;
  logic [7:0] o_mem_wdata;
  logic [13:0] mem_seen;
  logic [31:0] d;
  int num_errors = 0;
  int compares = 0;
  flash_lock_and_iap_gate i_dut (.i_clock, .i_resetn, .i_awvalid,
    .o_awready, .i_awaddr, .i_wvalid, .o_wready, .i_wdata,
    .i_wstrb(4'hf), .o_bvalid, .i_bready, .o_bresp, .i_arvalid,
    .o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp,
    .i_sp_valid, .i_sp_op, .i_sp_space, .i_sp_addr, .i_sp_wdata(8'h3c),
    .o_sp_ready, .o_sp_done, .o_sp_denied, .o_sp_rdata, .o_mem_req,
    .o_mem_op, .o_mem_space, .o_mem_addr, .o_mem_wdata,
    .o_mem_from_app, .i_mem_done, .i_mem_rdata, .i_fetch_valid,
    .i_fetch_addr, .o_fetch_deny, .o_rom_map_enable);
  flash_ctrl_model i_mem (.i_clock, .i_resetn, .i_req(o_mem_req),
    .i_addr(o_mem_addr), .o_done(i_mem_done), .o_rdata(i_mem_rdata));
  // payload of the last finished memory request
  always @(posedge i_clock) begin
    if (o_mem_req && i_mem_done) begin
      mem_seen <= {o_mem_op, o_mem_space, o_mem_from_app, o_mem_wdata};
    end
  end
  task automatic check(input string n, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clock);
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    i_awaddr <= a;
    i_wdata <= v;
    i_bready <= 1'h1;
    do begin
      @(posedge i_clock);
      if (o_awready) i_awvalid <= 1'h0;
      if (o_wready) i_wvalid <= 1'h0;
    end while (!o_bvalid);
    resp = o_bresp;
    i_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_clock);
    i_arvalid <= 1'h1;
    i_araddr <= a;
    i_rready <= 1'h1;
    do begin
      @(posedge i_clock);
      if (o_arready) i_arvalid <= 1'h0;
    end while (!o_rvalid);
    v = o_rdata;
    resp = o_rresp;
    i_rready <= 1'h0;
  endtask
  // serial port request; valid drops once taken, else it repeats
  task automatic sp(mem_op_t op, space_t s, logic [15:0] a, logic e);
    @(posedge i_clock);
    i_sp_valid <= 1'h1;
    i_sp_op <= op;
    i_sp_space <= s;
    i_sp_addr <= a;
    do begin
      @(posedge i_clock);
      if (o_sp_ready) i_sp_valid <= 1'h0;
    end while (!o_sp_done);
    check("denied", e, o_sp_denied);
  endtask
  task automatic fetch(input logic [15:0] a, input logic e);
    @(posedge i_clock);
    i_fetch_valid <= 1'h1;
    i_fetch_addr <= a;
    @(posedge i_clock);
    i_fetch_valid <= 1'h0;
    @(posedge i_clock);
    check("fetch deny", e, o_fetch_deny);
  endtask
  task automatic svc(logic [7:0] c, a, logic [15:0] p, logic [7:0] e);
    logic [31:0] v;
    wr(REG_CMD, c);
    wr(REG_ACC, a);
    wr(REG_DP0, p);
    wr(REG_DP1, 32'h0);
    wr(REG_AUX, 32'h1);
    check("rom map", 32'h1, o_rom_map_enable);
    wr(REG_GO, 32'h1);
    do rd(REG_STATUS, v); while (v[2]);
    rd(REG_ACC, v);
    check("acc", e, v);
  endtask
  task automatic complete_run;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    i_clock = 1'h0;
    forever #5 i_clock = ~i_clock;
  end
  // watchdog: the tests need a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge i_clock);
    num_errors++;
    complete_run;
  end
  initial begin
    repeat (8) @(posedge i_clock);
    i_resetn <= 1'h1;
    repeat (2) @(posedge i_clock);
    rd(REG_LOCKS, d);
    check("locks", 32'h00ffffff, d);
    sp(MOP_PROG, SPACE_FUSE, 16'h0008, 1'h0);
    check("mem req", {MOP_PROG, SPACE_FUSE, 1'h0, 8'h3c}, mem_seen);
    wr(REG_EXT, 32'h1);
    check("bresp", RESP_OKAY, resp);
    for (int m = 0; m < 3; m++) begin
      sp(MOP_PROG, SPACE_LOCK, m[15:0], 1'h0);
      sp(MOP_READ, SPACE_LOCK, m[15:0], 1'h0);
      check("lock byte", 8'h00, o_sp_rdata);
      rd(REG_STATUS, d);
      check("mode", m + 1, d[1:0]);
      sp(MOP_PROG, SPACE_FUSE, 16'h0008, 1'h1);
      sp(MOP_BLK_ERASE, SPACE_CODE, 16'h2000, 1'h1);
      sp(MOP_READ, SPACE_DATA, 16'h0012, m > 0);
      sp(MOP_READ, SPACE_MSIG, 16'h0001, 1'h0);
      sp(MOP_READ, SPACE_FUSE, 16'h0002, 1'h0);
      sp(MOP_READ, SPACE_USIG, 16'h0012, 1'h0);
      check("sig", 8'hb7, o_sp_rdata);
      sp(MOP_READ, SPACE_LOCK, 16'h0001, 1'h0);
      check("lock one", (m > 0) ? 8'h00 : 8'hff, o_sp_rdata);
      fetch(16'h8000, m == 2);
      fetch(16'h7fff, 1'h0);
    end
    wr(REG_EXT, 32'h0);
    fetch(16'h8000, 1'h0);
    svc(CMD_PROG_BYTE, 8'h5a, 16'h1234, ACC_DONE);
    check("mem req", {MOP_PROG, SPACE_CODE, 1'h1, 8'h5a}, mem_seen);
    svc(CMD_ERASE_BLOCK, 8'h11, 16'h4000, 8'h40);
    svc(CMD_READ_ID, 8'h11, 16'h0002, 8'ha5);
    sp(MOP_CHIP_ERASE, SPACE_CODE, 16'h0000, 1'h0);
    rd(REG_LOCKS, d);
    check("locks", 32'h00ffffff, d);
    sp(MOP_PROG, SPACE_CODE, 16'h0100, 1'h0);
    rd(8'h40, d);
    check("resp", RESP_SLVERR, resp);
    wr(8'h40, 32'h0);
    check("bresp", RESP_SLVERR, resp);
    complete_run;
  end
endmodule // flash_lock_and_iap_gate_bench
